/* File: src/bodm_pkg.sv */
// package: register map, field layout, reset values and timing of the monitor
package bodm_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_A     = 8'h00;
  localparam logic [7:0] IDX_CONTROL_B     = 8'h01;
  localparam logic [7:0] IDX_RESERVED_LO   = 8'h02;
  localparam logic [7:0] IDX_RESERVED_HI   = 8'h07;
  localparam logic [7:0] IDX_LEVEL_CONTROL = 8'h08;
  localparam logic [7:0] IDX_IRQ_CONTROL   = 8'h09;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'h0A;
  localparam logic [7:0] IDX_STATUS        = 8'h0B;
  localparam logic [7:0] IDX_PROTECT_KEY   = 8'h0C;
  localparam int         ADDR_SHIFT        = 2;

  // field positions
  localparam int POS_SAMPLE_RATE = 4;
  localparam int POS_RUN_MODE    = 2;
  localparam int POS_SLEEP_MODE  = 0;
  localparam int POS_LEVEL       = 0;
  localparam int POS_OFFSET      = 0;
  localparam int POS_TRIGGER     = 1;
  localparam int POS_IRQ_ENABLE  = 0;
  localparam int POS_IRQ_FLAG    = 0;
  localparam int POS_LEVEL_STATE = 0;

  // reset values of the software registers
  localparam logic [1:0] RST_OFFSET     = 2'h0;
  localparam logic [1:0] RST_TRIGGER    = 2'h0;
  localparam logic       RST_IRQ_ENABLE = 1'b0;
  localparam logic       RST_IRQ_FLAG   = 1'b0;
  localparam logic       RST_STATE      = 1'b0;

  // unlock key value is arbitrary; window counts bus transfers
  localparam logic [7:0] PROTECT_KEY    = 8'hA5;
  localparam logic [2:0] PROTECT_WINDOW = 3'h4;

  // sampling periods in microseconds and in cycles of the 125 MHz clock
  localparam int CLOCK_MHZ             = 125;
  localparam int SAMPLE_PERIOD_FAST_US = 1000;
  localparam int SAMPLE_PERIOD_SLOW_US = 8000;
  localparam int SAMPLE_FAST_CYCLES    = SAMPLE_PERIOD_FAST_US * CLOCK_MHZ;
  localparam int SAMPLE_SLOW_CYCLES    = SAMPLE_PERIOD_SLOW_US * CLOCK_MHZ;
  localparam int SAMPLE_COUNT_WIDTH    = 20;

  typedef enum logic [1:0] {
    BODM_MODE_OFF     = 2'h0,
    BODM_MODE_ON      = 2'h1,
    BODM_MODE_SAMPLED = 2'h2,
    BODM_MODE_ON_HOLD = 2'h3
  } bodm_mode_type;

  typedef enum logic [1:0] {
    BODM_TRIG_FALLING = 2'h0,
    BODM_TRIG_RISING  = 2'h1,
    BODM_TRIG_EITHER  = 2'h2,
    BODM_TRIG_RSVD    = 2'h3
  } bodm_trigger_type;

  // configuration fuse contents
  typedef struct packed {
    logic       sample_rate_select;
    logic [1:0] run_mode;
    logic [1:0] sleep_mode;
    logic [2:0] threshold_level;
  } bodm_fuse_type;

endpackage : bodm_pkg

/* File: src/bodm_sync.sv */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module bodm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage    <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end
endmodule : bodm_sync
`default_nettype wire

/* File: src/bodm_unlock.sv */
// change-protection window: opens on key write, closes after a few transfers
`timescale 1ns/1ps
`default_nettype none
module bodm_unlock (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic key_write,
  input  wire logic transfer_done,
  output var  logic unlocked
);
  logic [2:0] remaining;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remaining <= 3'h0;
    end else if (ce) begin
      if (key_write) begin
        remaining <= bodm_pkg::PROTECT_WINDOW;
      end else if (transfer_done && remaining != 3'h0) begin
        remaining <= remaining - 3'h1;
      end
    end
  end

  assign unlocked = (remaining != 3'h0);
endmodule : bodm_unlock
`default_nettype wire

/* File: src/bodm_top.sv */
// brownout monitor control and status registers with early-warning monitor
//
// What this block does
// - sample-rate bit 4 picks 1kHz when clear, 125Hz when set
// - sample-rate bit loads from fuse at reset; writes need unlock
// - run-mode bits 3:2: off, on, sampled, on with wake-up held
// - run-mode field loads from fuse at reset and is read-only
// - deep-sleep bits 1:0 write only after unlock; code 3 reserved
// - deep-sleep field loads from its fuse bits at reset
// - three-bit threshold level is read-only, from fuse, codes 0 to 7
// - warning offset code 0,1,2 sets 5, 15, 25 percent above threshold
// - trigger bits 2:1 pick falling, rising or either crossing
// - interrupt control bit 0 enables the early-warning interrupt
// - flag sets on configured crossing, never set while detector off
// - status bit reads one below warning threshold, zero above
// - status bit is meaningful only while the detector is enabled
// - interrupt request is high one cycle after flag and enable are both set (registered)
// - warning monitor is off with the detector and sampled with it
// - deep sleep uses the sleep-mode field, waking returns to run mode
`timescale 1ns/1ps
`default_nettype none
module bodm_top #(
  parameter int SAMPLE_FAST_CYCLES = bodm_pkg::SAMPLE_FAST_CYCLES,
  parameter int SAMPLE_SLOW_CYCLES = bodm_pkg::SAMPLE_SLOW_CYCLES
) (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire logic                    CLK_EN,
  // apb slave
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output var  logic [31:0]             PRDATA,
  output var  logic                    PREADY,
  output var  logic                    PSLVERR,
  // fuse contents, static while the device runs
  input  wire bodm_pkg::bodm_fuse_type DETECTOR_CONFIG_FUSE,
  // power manager: high while in standby or power-down
  input  wire logic                    DEEP_SLEEP,
  // analog comparator, asynchronous
  input  wire logic                    WARNING_BELOW,
  input  wire logic                    DETECTOR_READY,
  // towards the analog detector and the system
  output var  logic [1:0]              DETECTOR_MODE,
  output var  logic                    SAMPLE_STROBE,
  output var  logic [2:0]              THRESHOLD_LEVEL,
  output var  logic [1:0]              WARNING_OFFSET,
  output var  logic                    WAKE_HOLD,
  output var  logic                    WARNING_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic       sample_rate_select;
  logic [1:0] run_mode;
  logic [1:0] sleep_mode;
  logic [2:0] threshold_level;
  logic [1:0] warning_offset;
  logic [1:0] warning_trigger_select;
  logic       warning_irq_enable;
  logic       warning_irq_flag;
  logic       warning_level_state;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic       setup_phase;
  logic       access_done;
  logic       write_done;
  logic [7:0] reg_index;
  logic       addr_aligned;
  logic       unlocked;

  function automatic logic hits(input logic [7:0] index,
                                input logic [7:0] target,
                                input logic       aligned);
    hits = aligned && (index == target);
  endfunction : hits

  function automatic logic mapped(input logic [7:0] index,
                                  input logic       aligned);
    mapped = aligned && (index <= bodm_pkg::IDX_PROTECT_KEY);
  endfunction : mapped

  assign setup_phase  = PSEL && !PENABLE;
  assign access_done  = PSEL && PENABLE && PREADY;
  assign write_done   = access_done && PWRITE;
  assign reg_index    = {2'h0, PADDR[7:bodm_pkg::ADDR_SHIFT]};
  assign addr_aligned = (PADDR[1:0] == 2'h0);

  logic wr_control_a;
  logic wr_level_control;
  logic wr_irq_control;
  logic wr_irq_flags;
  logic wr_key;

  assign wr_control_a     = write_done &&
                            hits(reg_index, bodm_pkg::IDX_CONTROL_A,
                                 addr_aligned);
  assign wr_level_control = write_done &&
                            hits(reg_index, bodm_pkg::IDX_LEVEL_CONTROL,
                                 addr_aligned);
  assign wr_irq_control   = write_done &&
                            hits(reg_index, bodm_pkg::IDX_IRQ_CONTROL,
                                 addr_aligned);
  assign wr_irq_flags     = write_done &&
                            hits(reg_index, bodm_pkg::IDX_IRQ_FLAGS,
                                 addr_aligned);
  assign wr_key           = write_done &&
                            hits(reg_index, bodm_pkg::IDX_PROTECT_KEY,
                                 addr_aligned) &&
                            (PWDATA[7:0] == bodm_pkg::PROTECT_KEY);

  // the key write itself is not counted against the window
  bodm_unlock u_unlock (
    .clk           (CORE_CLK),
    .rst_n         (RST_N),
    .ce            (CLK_EN),
    .key_write     (wr_key),
    .transfer_done (access_done && !wr_key),
    .unlocked      (unlocked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // detector control, fuse-loaded

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sample_rate_select <= DETECTOR_CONFIG_FUSE.sample_rate_select;
      run_mode           <= DETECTOR_CONFIG_FUSE.run_mode;
      sleep_mode         <= DETECTOR_CONFIG_FUSE.sleep_mode;
      threshold_level    <= DETECTOR_CONFIG_FUSE.threshold_level;
    end else if (CLK_EN) begin
      // writes outside the unlock window leave the fields as they are
      if (wr_control_a && unlocked) begin
        sample_rate_select <= PWDATA[bodm_pkg::POS_SAMPLE_RATE];
        sleep_mode <= PWDATA[bodm_pkg::POS_SLEEP_MODE +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // warning configuration

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      warning_offset <= bodm_pkg::RST_OFFSET;
    end else if (CLK_EN && wr_level_control) begin
      warning_offset <= PWDATA[bodm_pkg::POS_OFFSET +: 2];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      warning_trigger_select <= bodm_pkg::RST_TRIGGER;
      warning_irq_enable     <= bodm_pkg::RST_IRQ_ENABLE;
    end else if (CLK_EN && wr_irq_control) begin
      warning_trigger_select <= PWDATA[bodm_pkg::POS_TRIGGER +: 2];
      warning_irq_enable     <= PWDATA[bodm_pkg::POS_IRQ_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mode

  logic                    deep_sleep_q;
  bodm_pkg::bodm_mode_type active_mode;
  logic                    detector_on;
  logic                    detector_sampled;

  // sleep code 3 is reserved and treated as off
  always_comb begin
    if (deep_sleep_q) begin
      active_mode = (sleep_mode == bodm_pkg::BODM_MODE_ON_HOLD) ?
                    bodm_pkg::BODM_MODE_OFF :
                    bodm_pkg::bodm_mode_type'(sleep_mode);
    end else begin
      active_mode = bodm_pkg::bodm_mode_type'(run_mode);
    end
  end

  assign detector_on      = (active_mode != bodm_pkg::BODM_MODE_OFF);
  assign detector_sampled = (active_mode == bodm_pkg::BODM_MODE_SAMPLED);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      deep_sleep_q <= 1'b0;
    end else if (CLK_EN) begin
      deep_sleep_q <= DEEP_SLEEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample tick

  logic [bodm_pkg::SAMPLE_COUNT_WIDTH-1:0] sample_count;
  logic [bodm_pkg::SAMPLE_COUNT_WIDTH-1:0] sample_last;
  logic                                    sample_tick;

  assign sample_last = sample_rate_select ?
    bodm_pkg::SAMPLE_COUNT_WIDTH'(SAMPLE_SLOW_CYCLES - 1) :
    bodm_pkg::SAMPLE_COUNT_WIDTH'(SAMPLE_FAST_CYCLES - 1);
  assign sample_tick = detector_sampled && (sample_count >= sample_last);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sample_count <= '0;
    end else if (CLK_EN) begin
      if (!detector_sampled || sample_tick) begin
        sample_count <= '0;
      end else begin
        sample_count <= sample_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator and crossing detection

  logic [1:0] comp_sync;
  logic       below_now;
  logic       ready_now;
  logic       take_sample;
  logic       went_below;
  logic       went_above;
  logic       crossing;

  bodm_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .ce       (CLK_EN),
    .async_in ({DETECTOR_READY, WARNING_BELOW}),
    .sync_out (comp_sync)
  );

  assign below_now = comp_sync[0];
  assign ready_now = comp_sync[1];

  // monitor follows the detector: off, continuous or on sample ticks
  assign take_sample = detector_on && (!detector_sampled || sample_tick);
  assign went_below  = take_sample && below_now && !warning_level_state;
  assign went_above  = take_sample && !below_now && warning_level_state;

  always_comb begin
    unique case (bodm_pkg::bodm_trigger_type'(warning_trigger_select))
      bodm_pkg::BODM_TRIG_FALLING: crossing = went_below;
      bodm_pkg::BODM_TRIG_RISING: crossing = went_above;
      bodm_pkg::BODM_TRIG_EITHER: crossing = went_below || went_above;
      bodm_pkg::BODM_TRIG_RSVD:    crossing = 1'b0;
    endcase
  end

  // status holds its last value while the detector is off
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      warning_level_state <= bodm_pkg::RST_STATE;
    end else if (CLK_EN && take_sample) begin
      warning_level_state <= below_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flag and request

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      warning_irq_flag <= bodm_pkg::RST_IRQ_FLAG;
    end else if (CLK_EN) begin
      if (crossing) begin
        warning_irq_flag <= 1'b1;
      end else if (wr_irq_flags && PWDATA[bodm_pkg::POS_IRQ_FLAG]) begin
        warning_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      WARNING_IRQ <= 1'b0;
    end else if (CLK_EN) begin
      WARNING_IRQ <= warning_irq_flag && warning_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detector outputs

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      DETECTOR_MODE   <= bodm_pkg::BODM_MODE_OFF;
      SAMPLE_STROBE   <= 1'b0;
      THRESHOLD_LEVEL <= 3'h0;
      WARNING_OFFSET  <= bodm_pkg::RST_OFFSET;
      WAKE_HOLD       <= 1'b0;
    end else if (CLK_EN) begin
      DETECTOR_MODE   <= active_mode;
      SAMPLE_STROBE   <= sample_tick;
      THRESHOLD_LEVEL <= threshold_level;
      WARNING_OFFSET  <= warning_offset;
      WAKE_HOLD       <= (run_mode == bodm_pkg::BODM_MODE_ON_HOLD) &&
                         !ready_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [7:0] read_byte;

  always_comb begin
    read_byte = 8'h00;
    if (addr_aligned) begin
      unique case (reg_index)
        bodm_pkg::IDX_CONTROL_A: begin
          read_byte[bodm_pkg::POS_SAMPLE_RATE]     = sample_rate_select;
          read_byte[bodm_pkg::POS_RUN_MODE +: 2]   = run_mode;
          read_byte[bodm_pkg::POS_SLEEP_MODE +: 2] = sleep_mode;
        end
        bodm_pkg::IDX_CONTROL_B: begin
          read_byte[bodm_pkg::POS_LEVEL +: 3] = threshold_level;
        end
        bodm_pkg::IDX_LEVEL_CONTROL: begin
          read_byte[bodm_pkg::POS_OFFSET +: 2] = warning_offset;
        end
        bodm_pkg::IDX_IRQ_CONTROL: begin
          read_byte[bodm_pkg::POS_TRIGGER +: 2] = warning_trigger_select;
          read_byte[bodm_pkg::POS_IRQ_ENABLE]   = warning_irq_enable;
        end
        bodm_pkg::IDX_IRQ_FLAGS: begin
          read_byte[bodm_pkg::POS_IRQ_FLAG] = warning_irq_flag;
        end
        bodm_pkg::IDX_STATUS: begin
          read_byte[bodm_pkg::POS_LEVEL_STATE] = warning_level_state;
        end
        default: begin
          read_byte = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: ready in the first access cycle

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= setup_phase;
      if (setup_phase) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, read_byte};
        PSLVERR <= !mapped(reg_index, addr_aligned);
      end else if (access_done) begin
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

endmodule : bodm_top
`default_nettype wire

/* File: verification/bodm_chk.sv */
// checker: port-level properties of the brownout monitor registers
`timescale 1ns/1ps
`default_nettype none
module bodm_chk #(
  parameter int SAMPLE_FAST_CYCLES = 10,
  parameter int SAMPLE_SLOW_CYCLES = 40
) (
  input wire logic                    CORE_CLK,
  input wire logic                    RST_N,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [7:0]              PADDR,
  input wire logic [31:0]             PRDATA,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  input wire bodm_pkg::bodm_fuse_type DETECTOR_CONFIG_FUSE,
  input wire logic                    DEEP_SLEEP,
  input wire logic [1:0]              DETECTOR_MODE,
  input wire logic                    SAMPLE_STROBE,
  input wire logic [2:0]              THRESHOLD_LEVEL,
  input wire logic                    WARNING_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic        rd_done;
  logic        irq_wr;
  logic [19:0] gap;
  logic        seen;
  assign rd_done = PREADY && PSEL && PENABLE && !PWRITE;
  assign irq_wr = PREADY && PSEL && PENABLE && PWRITE
                  && (PADDR == 8'h28 || PADDR == 8'h24);
  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last sample strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      gap  <= 20'h0;
      seen <= 1'b0;
    end else if (SAMPLE_STROBE) begin
      gap  <= 20'h0;
      seen <= 1'b1;
    end else if (gap != 20'hFFFFF) begin
      gap <= gap + 20'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  level_copy_a: assert property (RST_N && $past(RST_N) |->
    THRESHOLD_LEVEL == DETECTOR_CONFIG_FUSE.threshold_level)
    else $error("threshold level output differs from fuse");
  level_read_a: assert property (rd_done && PADDR == 8'h04 |->
    PRDATA == {29'h0, DETECTOR_CONFIG_FUSE.threshold_level})
    else $error("control b read differs from fuse level");
  run_mode_a: assert property ((!DEEP_SLEEP)[*3] |->
    DETECTOR_MODE == DETECTOR_CONFIG_FUSE.run_mode)
    else $error("awake mode differs from run mode");
  sleep_mode_a: assert property (DEEP_SLEEP[*3] |->
    DETECTOR_MODE != 2'h3)
    else $error("deep sleep mode shows held wake-up");
  run_read_a: assert property (rd_done && PADDR == 8'h00 |->
    PRDATA[3:2] == DETECTOR_CONFIG_FUSE.run_mode && PRDATA[7:5] == 3'h0)
    else $error("control a read shows wrong run mode");
  rsvd_zero_a: assert property (rd_done && PADDR[7:2] >= 6'h02 &&
    PADDR[7:2] <= 6'h07 |-> PRDATA == 32'h0)
    else $error("reserved register read not zero");
  misalign_err_a: assert property (PREADY && PADDR[1:0] != 2'h0
    |-> PSLVERR)
    else $error("misaligned access without error");
  strobe_mode_a: assert property (SAMPLE_STROBE |->
    DETECTOR_MODE == 2'h2 || $past(DETECTOR_MODE) == 2'h2)
    else $error("sample strobe outside sampled mode");
  strobe_gap_a: assert property (SAMPLE_STROBE && seen |->
    gap >= SAMPLE_FAST_CYCLES - 1)
    else $error("sample strobes too close");
  irq_hold_a: assert property ($fell(WARNING_IRQ) |->
    $past(irq_wr, 2))
    else $error("interrupt dropped without flag or enable write");
  slow_c: cover property (SAMPLE_STROBE && gap == SAMPLE_SLOW_CYCLES - 1);
endmodule : bodm_chk

bind bodm_top bodm_chk #(.SAMPLE_FAST_CYCLES(SAMPLE_FAST_CYCLES),
  .SAMPLE_SLOW_CYCLES(SAMPLE_SLOW_CYCLES)) chk_u (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DETECTOR_CONFIG_FUSE(DETECTOR_CONFIG_FUSE),
  .DEEP_SLEEP(DEEP_SLEEP), .DETECTOR_MODE(DETECTOR_MODE),
  .SAMPLE_STROBE(SAMPLE_STROBE), .THRESHOLD_LEVEL(THRESHOLD_LEVEL),
  .WARNING_IRQ(WARNING_IRQ));
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench: register map, unlock, sampling and warning interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic er;
  } bodm_row_type;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic ds = 0, below = 0, rdy = 0, ce = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, perr, strobe, hold, irq, er;
  logic [1:0]  mode, ofs;
  logic [2:0]  lvl;
  bodm_pkg::bodm_fuse_type fuse = 8'hC5;
  int n_errors = 0, checks = 0, cyc = 0;
  bodm_row_type rows [21] = '{
    '{0,8'h00,0,8'h18,0}, '{0,8'h04,0,8'h05,0}, '{0,8'h20,0,8'h00,0},
    '{0,8'h24,0,8'h00,0}, '{0,8'h28,0,8'h00,0}, '{0,8'h2C,0,8'h00,0},
    '{1,8'h20,8'hFF,0,0}, '{0,8'h20,0,8'h03,0}, '{1,8'h24,8'hFF,0,0},
    '{0,8'h24,0,8'h07,0}, '{1,8'h08,8'hFF,0,0}, '{0,8'h08,0,8'h00,0},
    '{1,8'h04,8'hFF,0,0}, '{0,8'h04,0,8'h05,0}, '{1,8'h00,8'h03,0,0},
    '{0,8'h00,0,8'h18,0}, '{0,8'h30,0,8'h00,0}, '{0,8'h34,0,0,1},
    '{0,8'h02,0,0,1}, '{1,8'h40,8'h01,0,1}, '{1,8'h24,8'h00,0,0}};
  bodm_top #(.SAMPLE_FAST_CYCLES(10), .SAMPLE_SLOW_CYCLES(40)) dut_u (
    .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
    .DETECTOR_CONFIG_FUSE(fuse), .DEEP_SLEEP(ds), .WARNING_BELOW(below),
    .DETECTOR_READY(rdy), .DETECTOR_MODE(mode), .SAMPLE_STROBE(strobe),
    .THRESHOLD_LEVEL(lvl), .WARNING_OFFSET(ofs), .WAKE_HOLD(hold),
    .WARNING_IRQ(irq));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic gap(input int e);
    int n;
    n = 0;
    while (strobe !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 200);
    chk("strobe gap", e, n);
  endtask : gap
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("error", rows[i].er, er);
      if (!rows[i].w) chk("read", rows[i].e, rd);
    end
    chk("offset out", 2'h3, ofs);
    chk("mode", 2'h2, mode);
    gap(40);
    apb(1, 8'h30, 8'hA5);
    for (int i = 0; i < 3; i++) apb(0, 8'h20, 8'h00);
    apb(1, 8'h00, 8'h0D);
    apb(0, 8'h00, 8'h00);
    chk("unlocked write", 8'h09, rd);
    repeat (50) @(posedge clk);
    gap(10);
    apb(1, 8'h30, 8'hA5);
    for (int i = 0; i < 4; i++) apb(0, 8'h20, 8'h00);
    apb(1, 8'h00, 8'h12);
    apb(0, 8'h00, 8'h00);
    chk("late write", 8'h09, rd);
    ds <= 1'b1;
    repeat (4) @(posedge clk);
    chk("sleep mode", 2'h1, mode);
    ds <= 1'b0;
    repeat (4) @(posedge clk);
    chk("wake mode", 2'h2, mode);
    apb(1, 8'h24, 8'h01);
    below <= 1'b1;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
    chk("irq sampled", 1'b1, irq);
    apb(0, 8'h2C, 8'h00);
    chk("status", 8'h01, rd);
    apb(1, 8'h28, 8'h00);
    apb(0, 8'h28, 8'h00);
    chk("flag kept", 8'h01, rd);
    apb(1, 8'h24, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 1'b0, irq);
    apb(1, 8'h24, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 1'b1, irq);
    apb(1, 8'h28, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    rst_n <= 1'b0;
    fuse <= 8'h7A;
    below <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("level out", 3'h2, lvl);
    chk("run mode", 2'h3, mode);
    chk("hold", 1'b1, hold);
    apb(0, 8'h20, 8'h00);
    chk("level reset", 8'h00, rd);
    apb(0, 8'h00, 8'h00);
    chk("fuse control a", 8'h0F, rd);
    // clock enable low must freeze the synchroniser and the hold output
    ce <= 1'b0;
    rdy <= 1'b1;
    repeat (5) @(posedge clk);
    chk("hold frozen", 1'b1, hold);
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk("hold released", 1'b0, hold);
    for (int t = 0; t < 4; t++) begin
      apb(1, 8'h24, {5'h0, t[1:0], 1'b1});
      apb(1, 8'h28, 8'h01);
      below <= 1'b1;
      repeat (8) @(posedge clk);
      apb(0, 8'h28, 8'h00);
      chk("flag fall", {31'h0, t == 0 || t == 2}, rd);
      apb(1, 8'h28, 8'h01);
      below <= 1'b0;
      repeat (8) @(posedge clk);
      apb(0, 8'h28, 8'h00);
      chk("flag rise", {31'h0, t == 1 || t == 2}, rd);
    end
    // trigger on either crossing so a live monitor would set the flag
    apb(1, 8'h24, 8'h05);
    ds <= 1'b1;
    apb(1, 8'h28, 8'h01);
    below <= 1'b1;
    repeat (8) @(posedge clk);
    chk("sleep reserved off", 2'h0, mode);
    apb(0, 8'h28, 8'h00);
    chk("flag off", 8'h00, rd);
    apb(0, 8'h2C, 8'h00);
    chk("status off", 8'h00, rd);
    ds <= 1'b0;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
